// >>> erb_pkg.sv
// constants, types and register map of the embedded ram block
`default_nettype none
package erb_pkg;
  // ******************************************************************
  // storage geometry
  // ******************************************************************
  localparam int unsigned ERB_BITS = 2048;
  localparam int unsigned ERB_ROWS = 256;
  localparam int unsigned ERB_DW = 8;
  localparam int unsigned ERB_AW = 11;
  localparam int unsigned ERB_IW = 8;

  // ******************************************************************
  // modes, aspect ratios and configuration word
  // ******************************************************************
  typedef enum logic [1:0] {ERB_RAM, ERB_ROM, ERB_DPRAM} erb_mode_t;
  typedef enum logic [1:0] {ERB_A256X8, ERB_A512X4, ERB_A1KX2, ERB_A2KX1} erb_aspect_t;
  typedef struct packed {
    logic locked;
    logic reg_dout;
    logic reg_addr;
    logic reg_din;
    erb_mode_t mode;
    erb_aspect_t aspect;
  } erb_cfg_t;
  localparam int unsigned ERB_CFG_W = 8;
  localparam logic [7:0] ERB_CFG_RST = 8'h00;

  // one fabric request: write enable, both addresses and write data
  typedef struct packed {
    logic we;
    logic [10:0] waddr;
    logic [10:0] raddr;
    logic [7:0] data;
  } erb_req_t;

  // where one word of the selected aspect lives inside the byte rows
  typedef struct packed {
    logic [7:0] idx;
    logic [2:0] off;
    logic [7:0] mask;
  } erb_loc_t;

  // ******************************************************************
  // register map, byte addresses
  // ******************************************************************
  localparam logic [11:0] ERB_OFF_CTRL = 12'h000;
  localparam logic [11:0] ERB_OFF_STATUS = 12'h004;
  localparam logic [11:0] ERB_OFF_LADDR = 12'h008;
  localparam logic [11:0] ERB_OFF_LDATA = 12'h00C;
  localparam logic [1:0] ERB_RESP_OKAY = 2'h0;
  localparam logic [1:0] ERB_RESP_SLVERR = 2'h2;
endpackage : erb_pkg
`default_nettype wire

// >>> erb_top.sv
// embedded ram block with axi4-lite configuration and preload port
// Behaviour
// - storage holds exactly 2048 bits, all usable as memory.
// - ram shapes 256x8, 512x4, 1024x2 or 2048x1, chosen at configuration.
// - block makes its own write strobe at the clock edge.
// - input registers and output register run on separate clock enables.
// - data-in, address/we and data-out registers each enabled or bypassed.
// - read-only contents loaded once at configuration, then looked up only.
// - usable as single-port ram, rom, dual-port ram or fifo store.
// - wider memories are parallel blocks sharing address and write enable.
// - cascaded depth to 2048 words keeps single-block access timing.
`default_nettype none
module erb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic ram_we,
  input wire logic [10:0] ram_waddr,
  input wire logic [10:0] ram_raddr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  // ******************************************************************
  // word location decode
  // ******************************************************************
  // maps a word address of the chosen aspect onto a byte row and lane
  function automatic erb_pkg::erb_loc_t erb_locate(input logic [10:0] a,
                                                   input erb_pkg::erb_aspect_t asp);
    erb_pkg::erb_loc_t l;
    l = '0;
    case (asp)
      erb_pkg::ERB_A256X8: begin
        l.idx = a[7:0];
        l.mask = 8'hFF;
      end
      erb_pkg::ERB_A512X4: begin
        l.idx = a[8:1];
        l.off = {a[0], 2'h0};
        l.mask = 8'h0F << l.off;
      end
      erb_pkg::ERB_A1KX2: begin
        l.idx = a[9:2];
        l.off = {a[1:0], 1'h0};
        l.mask = 8'h03 << l.off;
      end
      default: begin
        l.idx = a[10:3];
        l.off = a[2:0];
        l.mask = 8'h01 << l.off;
      end
    endcase
    return l;
  endfunction

  // ******************************************************************
  // state
  // ******************************************************************
  erb_pkg::erb_cfg_t cfg_r;
  logic [7:0] laddr_r;
  erb_pkg::erb_req_t req_r;
  logic [7:0] dout_r;
  logic [7:0] mem [erb_pkg::ERB_ROWS]; // 256 rows x 8 bits = 2048 bits
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [11:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ******************************************************************
  // axi4-lite write channel
  // ******************************************************************
  wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
  wire wr_en = wr_go & wstrb0_r;
  wire wr_hit = (awaddr_r == erb_pkg::ERB_OFF_CTRL) | (awaddr_r == erb_pkg::ERB_OFF_STATUS) |
                (awaddr_r == erb_pkg::ERB_OFF_LADDR) | (awaddr_r == erb_pkg::ERB_OFF_LDATA);
  wire wr_ctrl = wr_en & ~cfg_r.locked & (awaddr_r == erb_pkg::ERB_OFF_CTRL);
  wire wr_laddr = wr_en & (awaddr_r == erb_pkg::ERB_OFF_LADDR);
  wire load_we = wr_en & ~cfg_r.locked & (awaddr_r == erb_pkg::ERB_OFF_LDATA);
  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready = ~w_full_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // address and data are held separately and taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= erb_pkg::ERB_RESP_OKAY;
      awaddr_r <= '0;
      wbyte_r <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? erb_pkg::ERB_RESP_OKAY : erb_pkg::ERB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // configuration freezes once the lock bit is set; preload pointer steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= erb_pkg::erb_cfg_t'(erb_pkg::ERB_CFG_RST);
      laddr_r <= '0;
    end else begin
      if (wr_ctrl) begin
        cfg_r <= erb_pkg::erb_cfg_t'(wbyte_r); // once locked, held until reset
      end
      if (wr_laddr) begin
        laddr_r <= wbyte_r;
      end else if (load_we) begin
        laddr_r <= laddr_r + 8'h01;
      end
    end
  end

  // ******************************************************************
  // axi4-lite read channel
  // ******************************************************************
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  wire [31:0] rd_mux =
    (s_axi_araddr == erb_pkg::ERB_OFF_CTRL) ? {24'h000000, cfg_r} :
    (s_axi_araddr == erb_pkg::ERB_OFF_STATUS) ? {24'h000000, 7'h00, cfg_r.locked} :
    (s_axi_araddr == erb_pkg::ERB_OFF_LADDR) ? {24'h000000, laddr_r} :
    {24'h000000, mem[laddr_r]};
  wire rd_hit = (s_axi_araddr == erb_pkg::ERB_OFF_CTRL) |
                (s_axi_araddr == erb_pkg::ERB_OFF_STATUS) |
                (s_axi_araddr == erb_pkg::ERB_OFF_LADDR) |
                (s_axi_araddr == erb_pkg::ERB_OFF_LDATA);

  // one-cycle read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= erb_pkg::ERB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_hit ? rd_mux : 32'h00000000;
      rresp_r <= rd_hit ? erb_pkg::ERB_RESP_OKAY : erb_pkg::ERB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ******************************************************************
  // fabric input side: optional registers, then self-timed write
  // ******************************************************************
  wire erb_pkg::erb_req_t req_in = {ram_we, ram_waddr, ram_raddr, ram_wdata};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= '0;
    end else if (in_ce) begin
      req_r <= req_in; // input registers advance on the input-side enable
    end
  end
  // each register is chosen or bypassed on its own
  wire [7:0] din_eff = cfg_r.reg_din ? req_r.data : ram_wdata;
  wire we_eff = cfg_r.reg_addr ? req_r.we : ram_we;
  wire [10:0] waddr_eff = cfg_r.reg_addr ? req_r.waddr : ram_waddr;
  wire [10:0] raddr_eff = cfg_r.reg_addr ? req_r.raddr : ram_raddr;
  // dual-port reads its own address, single-port shares the write address
  wire [10:0] rd_addr = (cfg_r.mode == erb_pkg::ERB_DPRAM) ? raddr_eff : waddr_eff;
  // one address feeds every lane, so parallel blocks stay in step
  wire erb_pkg::erb_loc_t wl = erb_locate(waddr_eff, cfg_r.aspect);
  wire erb_pkg::erb_loc_t rl = erb_locate(rd_addr, cfg_r.aspect);
  wire [7:0] w_val = (din_eff << wl.off) & wl.mask;
  wire [7:0] w_old = mem[wl.idx];
  // writes only after lock and never in read-only mode
  wire user_wr = in_ce & we_eff & cfg_r.locked & (cfg_r.mode != erb_pkg::ERB_ROM);

  // storage: preload before lock, fabric writes after; strobe made here
  always_ff @(posedge aclk) begin
    if (load_we) begin
      mem[laddr_r] <= wbyte_r;
    end else if (user_wr) begin
      mem[wl.idx] <= (w_old & ~wl.mask) | w_val;
    end
  end

  // ******************************************************************
  // fabric output side
  // ******************************************************************
  wire [7:0] dmask = rl.mask >> rl.off;
  wire [7:0] rd_word = (mem[rl.idx] & rl.mask) >> rl.off; // low bits only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_r <= '0;
    end else if (out_ce) begin
      dout_r <= rd_word; // output register on its own enable
    end
  end
  // fixed one-step access path whatever the depth
  assign ram_rdata = cfg_r.reg_dout ? dout_r : rd_word;

  // ******************************************************************
  // assertions
  // ******************************************************************
  property p_write_lands;
    @(posedge aclk) disable iff (!aresetn)
    user_wr |=> ((mem[$past(wl.idx)] & $past(wl.mask)) == $past(w_val));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("fabric write not stored");

  property p_rom_frozen;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_r.locked && cfg_r.mode == erb_pkg::ERB_ROM) |=> (mem[$past(wl.idx)] == $past(w_old));
  endproperty
  a_rom_frozen: assert property (p_rom_frozen) else $error("read-only contents changed");

  property p_lock_sticky;
    @(posedge aclk) disable iff (!aresetn)
    cfg_r.locked |=> (cfg_r.locked && $stable(cfg_r));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("configuration changed after lock");

  property p_dout_reg;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_r.locked && cfg_r.reg_dout && out_ce) |=> (ram_rdata == $past(rd_word));
  endproperty
  a_dout_reg: assert property (p_dout_reg) else $error("output register missed load");

  property p_dout_hold;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_r.locked && cfg_r.reg_dout && !out_ce) |=> $stable(ram_rdata);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("output moved without enable");

  property p_din_reg;
    @(posedge aclk) disable iff (!aresetn)
    (cfg_r.locked && cfg_r.reg_din && in_ce) |=> (din_eff == $past(ram_wdata));
  endproperty
  a_din_reg: assert property (p_din_reg) else $error("data-in register missed load");

  property p_width;
    @(posedge aclk) disable iff (!aresetn)
    !cfg_r.reg_dout |-> ((ram_rdata & ~dmask) == 8'h00);
  endproperty
  a_width: assert property (p_width) else $error("read data wider than word");

  property p_dp_readback;
    @(posedge aclk) disable iff (!aresetn)
    (user_wr && cfg_r.mode == erb_pkg::ERB_DPRAM && !cfg_r.reg_dout) ##1
      (rd_addr == $past(waddr_eff)) |-> (ram_rdata == ($past(din_eff) & dmask));
  endproperty
  a_dp_readback: assert property (p_dp_readback) else $error("dual-port readback wrong");

  property p_bus_resp;
    @(posedge aclk) disable iff (!aresetn)
    wr_go |=> (s_axi_bvalid && (s_axi_bresp == ($past(wr_hit) ? 2'h0 : 2'h2)));
  endproperty
  a_bus_resp: assert property (p_bus_resp) else $error("write response wrong");

  c_load: cover property (@(posedge aclk) disable iff (!aresetn) load_we);
  c_rom_read: cover property (@(posedge aclk) disable iff (!aresetn)
    cfg_r.locked && cfg_r.mode == erb_pkg::ERB_ROM && out_ce);
  c_dp_write: cover property (@(posedge aclk) disable iff (!aresetn)
    user_wr && cfg_r.mode == erb_pkg::ERB_DPRAM && cfg_r.aspect == erb_pkg::ERB_A2KX1);
endmodule : erb_top
`default_nettype wire

// >>> erb_fabric_model.sv
// behavioural model of the fabric user logic that drives the ram port
`default_nettype none
module erb_fabric_model (
  input wire logic aclk,
  output logic in_ce,
  output logic out_ce,
  output logic ram_we,
  output logic [10:0] ram_waddr,
  output logic [10:0] ram_raddr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // port drivers
  // ******************************************************************
  // enables run every edge unless a test stalls the output side
  initial begin
    in_ce = 1'b1;
    out_ce = 1'b1;
    ram_we = 1'b0;
    ram_waddr = '0;
    ram_raddr = '0;
    ram_wdata = '0;
  end

  // one write strobe, held steady across the sampling edge
  task automatic write(input logic [10:0] a, input logic [7:0] v);
    @(posedge aclk);
    ram_we <= 1'b1;
    ram_waddr <= a;
    ram_wdata <= v;
    @(posedge aclk);
    ram_we <= 1'b0;
    ram_wdata <= ~v; // released data no longer carries the value
  endtask

  // present addresses only
  task automatic put(input logic [10:0] wa, input logic [10:0] ra);
    @(posedge aclk);
    ram_waddr <= wa;
    ram_raddr <= ra;
  endtask

  // read with room for every optional register stage
  task automatic rd(input logic [10:0] wa, input logic [10:0] ra, output logic [7:0] v);
    put(wa, ra);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    v = ram_rdata;
  endtask

  task automatic set_oce(input logic b);
    @(posedge aclk);
    out_ce <= b;
  endtask
endmodule // erb_fabric_model
`default_nettype wire

// >>> erb_top_tb.sv
// self-checking testbench of the embedded ram block
`default_nettype none
module erb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, in_ce, out_ce, ram_we;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [10:0] ram_waddr, ram_raddr;
  logic [7:0] ram_wdata, ram_rdata, q;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  erb_top erb_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .in_ce(in_ce), .out_ce(out_ce), .ram_we(ram_we),
    .ram_waddr(ram_waddr), .ram_raddr(ram_raddr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  erb_fabric_model erb_fabric_model_i (.aclk(aclk), .in_ce(in_ce), .out_ce(out_ce),
    .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_raddr(ram_raddr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata));

  // ******************************************************************
  // clock, watchdog and helpers
  // ******************************************************************
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a);
    logic ta, tb;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
  endtask

  // last probe of each shape sits at the top address
  function automatic logic [10:0] adr(int k, int i);
    return (i == 7) ? 11'((256 << k) - 1) : 11'(i * 3);
  endfunction

  function automatic logic [7:0] pat(int k, int i);
    return 8'(8'hA5 + i * 29) & 8'((9'h1 << (8 >> k)) - 1);
  endfunction

  // ******************************************************************
  // test sequence
  // ******************************************************************
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(erb_pkg::ERB_OFF_CTRL);
    check("ctrl reset", d, 32'h00);
    axi_rd(erb_pkg::ERB_OFF_STATUS);
    check("status reset", d, 32'h00);
    axi_rd(12'h010);
    check("unmapped resp", {30'h0, r}, {30'h0, erb_pkg::ERB_RESP_SLVERR});
    check("unmapped data", d, 32'h00);
    axi_wr(12'h010, 32'h01, 4'hF);
    check("unmapped bresp", {30'h0, r}, {30'h0, erb_pkg::ERB_RESP_SLVERR});
    axi_wr(erb_pkg::ERB_OFF_LADDR, 32'h10, 4'hF);
    check("laddr bresp", {30'h0, r}, {30'h0, erb_pkg::ERB_RESP_OKAY});
    axi_wr(erb_pkg::ERB_OFF_LADDR, 32'h77, 4'hE);
    axi_rd(erb_pkg::ERB_OFF_LADDR);
    check("laddr lane", d, 32'h10);
    check("laddr rresp", {30'h0, r}, {30'h0, erb_pkg::ERB_RESP_OKAY});
    axi_wr(erb_pkg::ERB_OFF_LDATA, 32'hA5, 4'hF);
    axi_wr(erb_pkg::ERB_OFF_LDATA, 32'h3C, 4'hF);
    axi_rd(erb_pkg::ERB_OFF_LADDR);
    check("laddr step", d, 32'h12);
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'h84, 4'hF);
    axi_rd(erb_pkg::ERB_OFF_STATUS);
    check("locked", d, 32'h01);
    erb_fabric_model_i.write(11'h010, 8'hFF);
    erb_fabric_model_i.rd(11'h010, 11'h010, q);
    check("rom word 0", {24'h0, q}, 32'hA5);
    erb_fabric_model_i.rd(11'h011, 11'h011, q);
    check("rom word 1", {24'h0, q}, 32'h3C);
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'h00, 4'hF);
    axi_rd(erb_pkg::ERB_OFF_CTRL);
    check("ctrl frozen", d, 32'h84);
    axi_wr(erb_pkg::ERB_OFF_LADDR, 32'h10, 4'hF);
    axi_wr(erb_pkg::ERB_OFF_LDATA, 32'h11, 4'hF);
    axi_rd(erb_pkg::ERB_OFF_LDATA);
    check("preload frozen", d, 32'hA5);
    $display("test rom done");
    for (int k = 0; k < 4; k++) begin
      do_reset();
      axi_wr(erb_pkg::ERB_OFF_CTRL, 32'h80 | k, 4'hF);
      for (int i = 0; i < 8; i++) erb_fabric_model_i.write(adr(k, i), pat(k, i));
      for (int i = 0; i < 8; i++) begin
        erb_fabric_model_i.rd(adr(k, i), adr(k, i), q);
        check("ram word", {24'h0, q}, {24'h0, pat(k, i)});
      end
    end
    $display("test shapes done");
    do_reset();
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'h80, 4'hF);
    erb_fabric_model_i.write(11'h005, 8'hAA);
    @(negedge aclk);
    check("write edge", {24'h0, ram_rdata}, 32'hAA);
    erb_fabric_model_i.write(11'h006, 8'h55);
    erb_fabric_model_i.put(11'h005, 11'h005);
    @(negedge aclk);
    check("bypass addr", {24'h0, ram_rdata}, 32'hAA);
    do_reset();
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'hA0, 4'hF);
    erb_fabric_model_i.rd(11'h005, 11'h005, q);
    erb_fabric_model_i.put(11'h006, 11'h006);
    @(negedge aclk);
    check("addr reg old", {24'h0, ram_rdata}, 32'hAA);
    @(negedge aclk);
    check("addr reg new", {24'h0, ram_rdata}, 32'h55);
    $display("test timing done");
    do_reset();
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'hF8, 4'hF);
    erb_fabric_model_i.write(11'h009, 8'h3C);
    erb_fabric_model_i.rd(11'h014, 11'h009, q);
    check("dual port", {24'h0, q}, 32'h3C);
    erb_fabric_model_i.rd(11'h005, 11'h005, q);
    erb_fabric_model_i.set_oce(1'b0);
    erb_fabric_model_i.rd(11'h006, 11'h006, q);
    check("out hold", {24'h0, q}, 32'hAA);
    erb_fabric_model_i.set_oce(1'b1);
    erb_fabric_model_i.rd(11'h006, 11'h006, q);
    check("out load", {24'h0, q}, 32'h55);
    $display("test dual port done");
    // dual-port single-bit shape, all bypassed, read address preset to the write address
    do_reset();
    axi_wr(erb_pkg::ERB_OFF_CTRL, 32'h8B, 4'hF);
    erb_fabric_model_i.put(11'h000, 11'h123);
    erb_fabric_model_i.write(11'h123, 8'hFF);
    @(negedge aclk);
    check("dp bit", {24'h0, ram_rdata}, 32'h01);
    erb_fabric_model_i.rd(11'h000, 11'h123, q);
    check("dp bit read", {24'h0, q}, 32'h01);
    $display("test bit port done");
    final_report();
  end
endmodule // erb_top_tb
`default_nettype wire
